//--- core/pieb_enable_bank.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
module pieb_enable_bank (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pieb_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [pieb_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [pieb_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire pieb_pkg::pieb_bank_t          irq_flags,
    output logic                               periph_irq_req,
    output logic                               core_irq_req
);

    // ****************************************************************
    // State
    // ****************************************************************
    pieb_pkg::pieb_state_t state;
    pieb_pkg::pieb_state_t next_state;

    logic                         access;
    logic                         wr_commit;
    logic [pieb_pkg::BYTE_MSB:0]  wr_byte;
    pieb_pkg::pieb_bank_t         flags_seen;
    pieb_pkg::pieb_bank_t         pending;

    // Access phase of an APB transfer; the write lands on the pready edge
    assign access    = psel && penable;
    assign wr_commit = access && state.pready && pwrite && pstrb[0];
    assign wr_byte   = pwdata[pieb_pkg::BYTE_MSB:0];

    // Flags are taken as they come, whatever the enables say
    assign flags_seen = irq_flags & pieb_pkg::BANK_MASK;
    // Bit n of each enable byte gates bit n of the same flag byte, nothing else
    assign pending    = '{four:  flags_seen.four  & state.enable.four,
                          three: flags_seen.three & state.enable.three,
                          two:   flags_seen.two   & state.enable.two,
                          one:   flags_seen.one   & state.enable.one};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state = state;

        // One wait state: pready rises in the second access cycle
        next_state.pready  = access && !state.pready;
        next_state.pslverr = 1'b0;
        next_state.prdata  = pieb_pkg::READ_ZERO;

        if (access && !state.pready) begin
            unique case (paddr)
                pieb_pkg::OFS_ENABLE_ONE: begin
                    next_state.prdata = {pieb_pkg::READ_PAD, state.enable.one};
                end
                pieb_pkg::OFS_ENABLE_TWO: begin
                    next_state.prdata = {pieb_pkg::READ_PAD, state.enable.two};
                end
                pieb_pkg::OFS_ENABLE_THREE: begin
                    next_state.prdata = {pieb_pkg::READ_PAD, state.enable.three};
                end
                pieb_pkg::OFS_ENABLE_FOUR: begin
                    next_state.prdata = {pieb_pkg::READ_PAD, state.enable.four};
                end
                pieb_pkg::OFS_CORE_CTRL: begin
                    next_state.prdata[pieb_pkg::CTRL_GLOBAL_BIT] = state.global_irq_en;
                    next_state.prdata[pieb_pkg::CTRL_GROUP_BIT]  = state.peripheral_group_irq_en;
                end
                pieb_pkg::OFS_FLAG_STATUS: begin
                    next_state.prdata = flags_seen;
                end
                pieb_pkg::OFS_PEND_STATUS: begin
                    next_state.prdata = pending;
                end
                default: begin
                    // Unmapped: error response, reads as zero, writes dropped
                    next_state.pslverr = 1'b1;
                end
            endcase
        end

        // Writes keep only implemented positions, so reserved bits stay zero
        if (wr_commit) begin
            unique case (paddr)
                pieb_pkg::OFS_ENABLE_ONE: begin
                    next_state.enable.one = wr_byte & pieb_pkg::MASK_ONE;
                end
                pieb_pkg::OFS_ENABLE_TWO: begin
                    next_state.enable.two = wr_byte & pieb_pkg::MASK_TWO;
                end
                pieb_pkg::OFS_ENABLE_THREE: begin
                    next_state.enable.three = wr_byte & pieb_pkg::MASK_THREE;
                end
                pieb_pkg::OFS_ENABLE_FOUR: begin
                    next_state.enable.four = wr_byte & pieb_pkg::MASK_FOUR;
                end
                pieb_pkg::OFS_CORE_CTRL: begin
                    next_state.global_irq_en           = wr_byte[pieb_pkg::CTRL_GLOBAL_BIT];
                    next_state.peripheral_group_irq_en = wr_byte[pieb_pkg::CTRL_GROUP_BIT];
                end
                default: begin
                    next_state.enable = state.enable;
                end
            endcase
        end

        // Every enable bit is a plain AND gate on its own flag
        next_state.periph_irq_req = |pending;
        // Forwarding needs both the group enable and the global enable
        next_state.core_irq_req   = (|pending) && state.peripheral_group_irq_en
                                    && state.global_irq_en;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.enable                  <= pieb_pkg::BANK_RESET;
            state.peripheral_group_irq_en <= 1'b0;
            state.global_irq_en           <= 1'b0;
            state.pready                  <= 1'b0;
            state.pslverr                 <= 1'b0;
            state.prdata                  <= pieb_pkg::READ_ZERO;
            state.periph_irq_req          <= 1'b0;
            state.core_irq_req            <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign prdata         = state.prdata;
    assign pready         = state.pready;
    assign pslverr        = state.pslverr;
    assign periph_irq_req = state.periph_irq_req;
    assign core_irq_req   = state.core_irq_req;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    timer_gate_en_a: assert property (
        (state.enable.one[7] && irq_flags.one[7]) |=> periph_irq_req)
        else $error("timer-one gate request not passed");

    converter_en_a: assert property (
        (state.enable.one[6] && irq_flags.one[6]) |=> periph_irq_req)
        else $error("converter request not passed");

    serial_en_a: assert property (
        (state.enable.one[5] && irq_flags.one[5]) || (state.enable.one[4] && irq_flags.one[4])
        |=> periph_irq_req)
        else $error("serial request not passed");

    sync_serial_en_a: assert property (
        (state.enable.one[3] && irq_flags.one[3]) |=> periph_irq_req)
        else $error("sync serial request not passed");

    capture_en_a: assert property (
        (state.enable.one[2] && irq_flags.one[2]) || (state.enable.two[0] && irq_flags.two[0])
        |=> periph_irq_req)
        else $error("capture request not passed");

    timer_match_en_a: assert property (
        (state.enable.one[1] && irq_flags.one[1]) || (|(state.enable.two[2:1] & irq_flags.two[2:1]))
        |=> periph_irq_req)
        else $error("timer match request not passed");

    overflow_en_a: assert property (
        (state.enable.one[0] && irq_flags.one[0]) |=> periph_irq_req)
        else $error("timer-one overflow request not passed");

    comparator_en_a: assert property (
        (|(state.enable.two[6:5] & irq_flags.two[6:5])) |=> periph_irq_req)
        else $error("comparator request not passed");

    collision_en_a: assert property (
        (state.enable.two[3] && irq_flags.two[3]) |=> periph_irq_req)
        else $error("bus collision request not passed");

    group_gate_a: assert property (
        core_irq_req |-> $past(state.peripheral_group_irq_en))
        else $error("core request without group enable");

    waveform_zc_en_a: assert property (
        (|(state.enable.three[5:4] & irq_flags.three[5:4])) |=> periph_irq_req)
        else $error("waveform or zero-cross request not passed");

    logic_cell_en_a: assert property (
        (|(state.enable.three[1:0] & irq_flags.three[1:0])) |=> periph_irq_req)
        else $error("logic cell request not passed");

    scan_crc_en_a: assert property (
        (|(state.enable.four[7:6] & irq_flags.four[7:6])) |=> periph_irq_req)
        else $error("scanner or checksum request not passed");

    meas_two_en_a: assert property (
        (|(state.enable.four[5:3] & irq_flags.four[5:3])) |=> periph_irq_req)
        else $error("measurement two request not passed");

    meas_one_en_a: assert property (
        (|(state.enable.four[2:0] & irq_flags.four[2:0])) |=> periph_irq_req)
        else $error("measurement one request not passed");

    reserved_zero_a: assert property (
        ((state.enable & ~pieb_pkg::BANK_MASK) == pieb_pkg::BANK_RESET)
        && !(pready && !pslverr && $past(paddr) == pieb_pkg::OFS_ENABLE_TWO
             && prdata[7] | prdata[4]))
        else $error("reserved enable bit set");

    enable_write_a: assert property (
        (wr_commit && paddr == pieb_pkg::OFS_ENABLE_ONE)
        |=> state.enable.one == $past(wr_byte))
        else $error("enable one write lost");

    flag_read_a: assert property (
        (access && !pready && !pwrite && paddr == pieb_pkg::OFS_FLAG_STATUS)
        |=> prdata == $past(flags_seen))
        else $error("flag status not independent of enables");

    global_gate_a: assert property (
        !state.global_irq_en ##1 !state.global_irq_en |-> !core_irq_req)
        else $error("core request while global enable clear");

    forward_a: assert property (
        (periph_irq_req && state.peripheral_group_irq_en && state.global_irq_en
         && $stable(state.enable) && $stable(irq_flags)
         && $stable(state.peripheral_group_irq_en) && $stable(state.global_irq_en))
        |=> core_irq_req)
        else $error("enabled request not forwarded");

    apb_wait_a: assert property (
        (psel && !penable) ##1 access |-> !pready ##1 pready)
        else $error("slave answer not after one wait state");

    // ****************************************************************
    // Blocking, write and bus checks
    // ****************************************************************
    // Judged from raw flags and enables, so a dropped enable term shows up here
    logic gated_off;
    assign gated_off = ((irq_flags & state.enable) == '0);

    timer_gate_off_a: assert property (
        (irq_flags.one[7] && gated_off) |=> !periph_irq_req)
        else $error("timer-one gate request not blocked");

    converter_off_a: assert property (
        (irq_flags.one[6] && gated_off) |=> !periph_irq_req)
        else $error("converter request not blocked");

    serial_off_a: assert property (
        ((|irq_flags.one[5:4]) && gated_off) |=> !periph_irq_req)
        else $error("serial request not blocked");

    sync_serial_off_a: assert property (
        (irq_flags.one[3] && gated_off) |=> !periph_irq_req)
        else $error("sync serial request not blocked");

    capture_off_a: assert property (
        ((irq_flags.one[2] || irq_flags.two[0]) && gated_off) |=> !periph_irq_req)
        else $error("capture request not blocked");

    timer_match_off_a: assert property (
        ((irq_flags.one[1] || (|irq_flags.two[2:1])) && gated_off) |=> !periph_irq_req)
        else $error("timer match request not blocked");

    overflow_off_a: assert property (
        (irq_flags.one[0] && gated_off) |=> !periph_irq_req)
        else $error("timer-one overflow request not blocked");

    comparator_off_a: assert property (
        ((|irq_flags.two[6:5]) && gated_off) |=> !periph_irq_req)
        else $error("comparator request not blocked");

    collision_off_a: assert property (
        (irq_flags.two[3] && gated_off) |=> !periph_irq_req)
        else $error("bus collision request not blocked");

    waveform_zc_off_a: assert property (
        ((|irq_flags.three[5:4]) && gated_off) |=> !periph_irq_req)
        else $error("waveform or zero-cross request not blocked");

    logic_cell_off_a: assert property (
        ((|irq_flags.three[1:0]) && gated_off) |=> !periph_irq_req)
        else $error("logic cell request not blocked");

    scan_crc_off_a: assert property (
        ((|irq_flags.four[7:6]) && gated_off) |=> !periph_irq_req)
        else $error("scanner or checksum request not blocked");

    meas_two_off_a: assert property (
        ((|irq_flags.four[5:3]) && gated_off) |=> !periph_irq_req)
        else $error("measurement two request not blocked");

    meas_one_off_a: assert property (
        ((|irq_flags.four[2:0]) && gated_off) |=> !periph_irq_req)
        else $error("measurement one request not blocked");

    req_off_a: assert property (
        gated_off |=> !periph_irq_req)
        else $error("request without enabled flag");

    core_from_req_a: assert property (
        core_irq_req |-> $past(!gated_off))
        else $error("core request without enabled flag");

    group_off_a: assert property (
        !state.peripheral_group_irq_en |=> !core_irq_req)
        else $error("core request while group enable clear");

    ctrl_write_a: assert property (
        (wr_commit && paddr == pieb_pkg::OFS_CORE_CTRL)
        |=> state.global_irq_en == $past(wr_byte[pieb_pkg::CTRL_GLOBAL_BIT])
            && state.peripheral_group_irq_en == $past(wr_byte[pieb_pkg::CTRL_GROUP_BIT]))
        else $error("core control write lost");

    write_two_a: assert property (
        (wr_commit && paddr == pieb_pkg::OFS_ENABLE_TWO)
        |=> state.enable.two == ($past(wr_byte) & pieb_pkg::MASK_TWO))
        else $error("enable two write wrong");

    write_three_a: assert property (
        (wr_commit && paddr == pieb_pkg::OFS_ENABLE_THREE)
        |=> state.enable.three == ($past(wr_byte) & pieb_pkg::MASK_THREE))
        else $error("enable three write wrong");

    write_four_a: assert property (
        (wr_commit && paddr == pieb_pkg::OFS_ENABLE_FOUR)
        |=> state.enable.four == $past(wr_byte))
        else $error("enable four write lost");

    strobe_drop_a: assert property (
        (access && pready && pwrite && !pstrb[0]) |=> $stable(state.enable))
        else $error("write without strobe changed an enable");

    pready_pulse_a: assert property (
        pready |=> !pready)
        else $error("pready longer than one cycle");

    error_ready_a: assert property (
        pslverr |-> pready)
        else $error("error response without pready");

    rdata_idle_a: assert property (
        !pready |-> prdata == pieb_pkg::READ_ZERO)
        else $error("read data outside the answer cycle");

    idle_ready_a: assert property (
        !psel |=> !pready)
        else $error("pready without a transfer");

endmodule // pieb_enable_bank

//--- core/pieb_pkg.sv
// ****************************************************************
// Package for the peripheral interrupt enable bank
// ****************************************************************
package pieb_pkg;

    localparam int BYTE_W   = 8;
    localparam int BYTE_MSB = BYTE_W - 1;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;

    // ****************************************************************
    // Register map, one aligned word per register
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_ENABLE_ONE   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_TWO   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_THREE = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_FOUR  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_CORE_CTRL    = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_FLAG_STATUS  = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_PEND_STATUS  = 12'h018;

    // ****************************************************************
    // Implemented bit masks and reset values
    // ****************************************************************
    localparam logic [BYTE_MSB:0] MASK_ONE   = 8'hff;
    localparam logic [BYTE_MSB:0] MASK_TWO   = 8'h6f;
    localparam logic [BYTE_MSB:0] MASK_THREE = 8'h33;
    localparam logic [BYTE_MSB:0] MASK_FOUR  = 8'hff;
    localparam logic [BYTE_MSB:0] RESET_BYTE = 8'h00;
    localparam logic [DATA_W-BYTE_W-1:0] READ_PAD = 24'h000000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

    // Bit positions in the core control register
    localparam int CTRL_GLOBAL_BIT = 7;
    localparam int CTRL_GROUP_BIT  = 6;

    // One byte per enable register, also used for the source flags
    typedef struct packed {
        logic [BYTE_MSB:0] four;
        logic [BYTE_MSB:0] three;
        logic [BYTE_MSB:0] two;
        logic [BYTE_MSB:0] one;
    } pieb_bank_t;

    localparam pieb_bank_t BANK_MASK = '{four: MASK_FOUR, three: MASK_THREE, two: MASK_TWO, one: MASK_ONE};
    localparam pieb_bank_t BANK_RESET = '{four: RESET_BYTE, three: RESET_BYTE, two: RESET_BYTE, one: RESET_BYTE};

    typedef struct packed {
        pieb_bank_t        enable;
        logic              peripheral_group_irq_en;
        logic              global_irq_en;
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
        logic              periph_irq_req;
        logic              core_irq_req;
    } pieb_state_t;

endpackage

//--- verification/pieb_flag_source.sv
`timescale 1ns/100ps
// ****************************************************************
// Peripheral flag sources on the far side of the enable bank
// ****************************************************************
module pieb_flag_source (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire pieb_pkg::pieb_bank_t events,
    input  wire logic                 clear_all,
    output pieb_pkg::pieb_bank_t      irq_flags
);
    // Flags stick until cleared and ignore every enable; an event in the clear cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags <= '0;
        end else if (clear_all) begin
            irq_flags <= events;
        end else begin
            irq_flags <= irq_flags | events;
        end
    end
endmodule // pieb_flag_source

//--- verification/tb_peripheral_interrupt_enable_bank.sv
`timescale 1ns/100ps
module tb_peripheral_interrupt_enable_bank;
    logic                           pclk = 1'b0;
    logic                           presetn, psel, penable, pwrite, pready, pslverr, err, clear_all;
    logic                           periph_irq_req, core_irq_req;
    logic [pieb_pkg::ADDR_W-1:0]    paddr;
    logic [pieb_pkg::ADDR_W-1:0]    ofs [5];
    logic [31:0]                    pwdata, prdata, rd, rnd, fl, en_exp;
    logic [3:0]                     pstrb;
    logic [7:0]                     ctrl;
    pieb_pkg::pieb_bank_t           irq_flags, events;
    int                             n_mismatch = 0, checks = 0, cycles = 0;

    always #10 pclk = ~pclk;

    pieb_enable_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_flags(irq_flags), .periph_irq_req(periph_irq_req), .core_irq_req(core_irq_req));
    pieb_flag_source src (.pclk(pclk), .presetn(presetn), .events(events), .clear_all(clear_all),
        .irq_flags(irq_flags));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] pend(input logic [31:0] f, input logic [31:0] e);
        return f & e & pieb_pkg::BANK_MASK;
    endfunction

    task automatic end_sim;
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A hung bench costs far more than any sane run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Called just after a rising edge; returns one edge after the one where pready was seen
    task automatic apb(input logic w, input logic [pieb_pkg::ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit of its own: only the bench timeout ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle, so the next call never re-drives psel in this time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [pieb_pkg::ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h1, rd, err);
    endtask

    task automatic rd_chk(input logic [pieb_pkg::ADDR_W-1:0] a, input logic [31:0] e, input logic e_err);
        apb(1'b0, a, 32'h00000000, 4'h0, rd, err);
        cmp32(rd, e);
        cmp1(err, e_err);
    endtask

    task automatic set_flags(input logic [31:0] v);
        clear_all <= 1'b1;
        events <= v;
        @(posedge pclk);
        clear_all <= 1'b0;
        events <= '0;
        fl = v;
    endtask

    // Flags land one edge, the request the next; look after both have settled
    task automatic irq_chk;
        repeat (2) @(posedge pclk);
        cmp1(periph_irq_req, |pend(fl, en_exp));
        cmp1(core_irq_req, (|pend(fl, en_exp)) & ctrl[pieb_pkg::CTRL_GLOBAL_BIT] & ctrl[pieb_pkg::CTRL_GROUP_BIT]);
    endtask

    task automatic do_reset(input int n);
        presetn <= 1'b0;
        repeat (n) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        en_exp = '0;
        ctrl = '0;
        fl = '0;
        for (int k = 0; k < 5; k++) begin
            rd_chk(ofs[k], 32'h00000000, 1'b0);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        events = '0;
        clear_all = 1'b0;
        rnd = 32'h00000024;
        ofs = '{pieb_pkg::OFS_ENABLE_ONE, pieb_pkg::OFS_ENABLE_TWO, pieb_pkg::OFS_ENABLE_THREE,
                pieb_pkg::OFS_ENABLE_FOUR, pieb_pkg::OFS_CORE_CTRL};
        do_reset(12);
        apb(1'b1, 12'hffc, 32'hffffffff, 4'hf, rd, err);
        cmp1(err, 1'b1);
        rd_chk(12'hffc, 32'h00000000, 1'b1);
        apb(1'b1, ofs[0], 32'h000000ff, 4'h0, rd, err);
        rd_chk(ofs[0], 32'h00000000, 1'b0);
        ctrl = 8'hc0;
        wr(ofs[4], 32'h000000c0);
        // Walk one enable and one flag across all 32 places, then its complement
        for (int b = 0; b < 32; b++) begin
            wr(ofs[b / 8], 32'h00000001 << (b % 8));
            en_exp = (32'h00000001 << b) & pieb_pkg::BANK_MASK;
            set_flags(32'h00000001 << b);
            irq_chk();
            set_flags(~(32'h00000001 << b));
            irq_chk();
            wr(ofs[b / 8], 32'h00000000);
            en_exp = '0;
        end
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            wr(ofs[i % 4], rnd);
            en_exp[(i % 4) * 8 +: 8] = rnd[7:0] & pieb_pkg::BANK_MASK[(i % 4) * 8 +: 8];
            rd_chk(ofs[i % 4], {24'h000000, en_exp[(i % 4) * 8 +: 8]}, 1'b0);
            ctrl = {i[1:0], 6'h00};
            wr(ofs[4], {rnd[31:8], i[1:0], rnd[5:0]});
            rd_chk(ofs[4], {24'h000000, ctrl}, 1'b0);
            rnd = lfsr(rnd);
            set_flags(rnd);
            irq_chk();
            rd_chk(pieb_pkg::OFS_FLAG_STATUS, fl & pieb_pkg::BANK_MASK, 1'b0);
            rd_chk(pieb_pkg::OFS_PEND_STATUS, pend(fl, en_exp), 1'b0);
        end
        do_reset(2);
        irq_chk();
        end_sim();
    end
endmodule // tb_peripheral_interrupt_enable_bank
